// ===== core/dca_core.sv
// Command decode, bank tracking, refresh and posted column access
// Functional notes
// - CS low, RAS high, CAS low, WE high, AP low decodes column read.
// - Same with WE low decodes column write into open row.
// - Read with auto precharge closes bank additive latency plus half burst later.
// - Write with auto precharge closes bank after burst plus write recovery.
// - Precharge all closes every bank, bank bits ignored.
// - CS, RAS, CAS low, WE high, CKE low enters self refresh.
// - DLL off in self refresh, on at exit; only CKE heard.
// - Auto refresh uses internal row counter, ignores address and bank.
// - After refresh all banks idle; refresh busy for cycle time.
// - NOP changes no internal state.
// - Deselect ignores strobes and address, acts as NOP.
// - Bursts stay within the four or eight column segment.
// - Column command held internally for additive latency.
// - Read latency is additive plus column; write latency one less.
// - Additive latency zero through six supported.
// - Burst length from code bits, type from type bit.
`timescale 1ns/1ns
module dca_core (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CLK_EN,
    input wire logic CKE,
    input wire logic CS_N,
    input wire logic RAS_N,
    input wire logic CAS_N,
    input wire logic WE_N,
    input wire logic [2:0] BANK_SEL,
    input wire logic [13:0] ADDR,
    input wire logic [2:0] BURST_CODE,
    input wire logic BURST_TYPE,
    input wire logic [2:0] ADD_LAT,
    input wire logic [2:0] COL_LAT,
    input wire logic [2:0] WR_REC,
    input wire logic COL_READY,
    output logic COL_VALID,
    output logic [dca_pkg::FW-1:0] COL_WORD,
    output logic [7:0] BANK_OPEN,
    output logic [7:0] AP_FIRE,
    output logic DLL_ON,
    output logic SELF_REF,
    output logic REF_BUSY,
    output logic [13:0] REF_ROW,
    output logic [3:0] RD_LAT,
    output logic [3:0] WR_LAT,
    output logic CMD_OVERRUN
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [dca_pkg::PINW-1:0] s1;
        logic [dca_pkg::PINW-1:0] s2;
        logic [dca_pkg::PINW-1:0] s3;
        logic [dca_pkg::PINW-1:0] pin;
        logic fresh;
        dca_pkg::dca_mode_t mode;
        logic [7:0] open;
        logic [7:0] fire;
        logic [7:0][4:0] ap;
        logic [dca_pkg::PIPE-1:0][dca_pkg::FW:0] pipe;
        logic [13:0] row;
        logic [7:0] busy;
        logic [9:0] srt;
        logic dll;
        logic [3:0] rl;
        logic [3:0] wl;
        logic ovr;
        logic sref;
        logic bsy;
    } dca_state_t;
    dca_state_t s, n;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic dca_pkg::dca_cmd_t decode(input logic [dca_pkg::PINW-1:0] p);
        logic [3:0] c;
        c = {p[dca_pkg::P_CS], p[dca_pkg::P_RAS], p[dca_pkg::P_CAS], p[dca_pkg::P_WE]};
        decode = dca_pkg::C_NOP;
        unique case (c)
            4'h3: decode = dca_pkg::C_ACT;
            4'h5: decode = p[dca_pkg::P_AP] ? dca_pkg::C_RD : dca_pkg::C_RD;
            4'h4: decode = dca_pkg::C_WR;
            4'h2: decode = p[dca_pkg::P_AP] ? dca_pkg::C_PREA : dca_pkg::C_PRE;
            4'h1: decode = p[dca_pkg::P_CKE] ? dca_pkg::C_REF : dca_pkg::C_SRE;
            default: decode = dca_pkg::C_NOP;
        endcase
    endfunction
    function automatic logic [4:0] ap_len(input logic [2:0] al, input logic [2:0] cl,
                                          input logic bl8, input logic wr, input logic [2:0] wrc);
        logic [4:0] half;
        half = bl8 ? 5'h4 : 5'h2;
        if (wr) begin
            ap_len = 5'(al) + 5'(cl) - 5'h1 + half + 5'(wrc);
        end else begin
            ap_len = 5'(al) + half;
        end
    endfunction
    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    dca_pkg::dca_cmd_t cmd;
    logic [2:0] al;
    logic bl8;
    logic [2:0] bank;
    logic apb;
    logic [dca_pkg::FW:0] nw;
    logic [dca_pkg::FW:0] emit;
    logic f_ready;
    always_comb begin
        n = s;
        n.s1 = {CKE, CS_N, RAS_N, CAS_N, WE_N, BANK_SEL, ADDR};
        n.s2 = s.s1;
        n.s3 = s.s2;
        n.fresh = 1'b0;
        if (s.s2 == s.s3 && s.s3 != s.pin) begin
            n.pin = s.s3;
        end
        // A held command is seen once per clock; repeats count again
        if (s.s2 == s.s3) begin
            n.pin = s.s3;
            n.fresh = 1'b1;
        end
        al = (ADD_LAT > dca_pkg::AL_MAX) ? dca_pkg::AL_MAX : ADD_LAT;
        bl8 = BURST_CODE == dca_pkg::BL8_CODE;
        bank = s.pin[dca_pkg::P_BA +: 3];
        apb = s.pin[dca_pkg::P_AP];
        cmd = s.fresh ? decode(s.pin) : dca_pkg::C_NOP;
        n.rl = 4'(al) + 4'(COL_LAT);
        n.wl = 4'(al) + 4'(COL_LAT) - 4'h1;
        n.fire = '0;
        for (int b = 0; b < 8; b++) begin
            if (s.ap[b] != 5'h0) begin
                n.ap[b] = s.ap[b] - 5'h1;
                if (s.ap[b] == 5'h1) begin
                    n.fire[b] = 1'b1;
                    n.open[b] = 1'b0;
                end
            end
        end
        if (s.busy != 8'h0) begin
            n.busy = s.busy - 8'h1;
        end
        // Column word: write, type, length, bank, start column
        nw = {1'b0, 1'b0, BURST_TYPE, bl8, bank, s.pin[dca_pkg::COLW-1:0]};
        n.pipe = {s.pipe[dca_pkg::PIPE-2:0], {(dca_pkg::FW+1){1'b0}}};
        unique case (s.mode)
            dca_pkg::M_RUN: begin
                unique case (cmd)
                    dca_pkg::C_ACT: n.open[bank] = 1'b1;
                    dca_pkg::C_RD: begin
                        nw[dca_pkg::FW] = 1'b1;
                        if (apb) begin
                            n.ap[bank] = ap_len(al, COL_LAT, bl8, 1'b0, WR_REC);
                        end
                    end
                    dca_pkg::C_WR: begin
                        nw[dca_pkg::FW] = 1'b1;
                        nw[dca_pkg::FW-1] = 1'b1;
                        if (apb) begin
                            n.ap[bank] = ap_len(al, COL_LAT, bl8, 1'b1, WR_REC);
                        end
                    end
                    dca_pkg::C_PRE: begin
                        n.open[bank] = 1'b0;
                        n.ap[bank] = 5'h0;
                    end
                    dca_pkg::C_PREA: begin
                        n.open = 8'h0;
                        n.ap = '0;
                    end
                    dca_pkg::C_REF: begin
                        n.open = 8'h0;
                        n.row = s.row + 14'h1;
                        n.busy = 8'(dca_pkg::REFRESH_CYCLE_TIME_CYC);
                    end
                    dca_pkg::C_SRE: begin
                        n.mode = dca_pkg::M_SREF;
                        n.dll = 1'b0;
                        n.srt = '0;
                        n.open = 8'h0;
                    end
                    default: begin
                    end
                endcase
            end
            dca_pkg::M_SREF: begin
                // Only CKE is heard here; internal timer refreshes rows
                if (s.srt == 10'(dca_pkg::SRT_CYC - 1)) begin
                    n.srt = '0;
                    n.row = s.row + 14'h1;
                end else begin
                    n.srt = s.srt + 10'h1;
                end
                if (s.fresh && s.pin[dca_pkg::P_CKE]) begin
                    n.mode = dca_pkg::M_EXIT;
                end
            end
            dca_pkg::M_EXIT: begin
                n.dll = 1'b1;
                n.mode = dca_pkg::M_RUN;
            end
        endcase
        // Status flags kept in flops so the outputs never glitch
        n.sref = n.mode == dca_pkg::M_SREF;
        n.bsy = n.busy != 8'h0;
        n.pipe[0] = nw;
        // Posted column command leaves the delay line after al clocks
        emit = (al == 3'h0) ? nw : s.pipe[al - 3'h1];
        if (emit[dca_pkg::FW] && !f_ready) begin
            n.ovr = 1'b1;
        end
    end
    // ------------------------------------------------------------
    // Column FIFO
    // ------------------------------------------------------------
    dca_fifo #(
        .W(dca_pkg::FW),
        .D(dca_pkg::FD)
    ) u_fifo (
        .clk(SYS_CLK),
        .rst(RST),
        .ce(CLK_EN),
        .in_valid(emit[dca_pkg::FW]),
        .in_data(emit[dca_pkg::FW-1:0]),
        .in_ready(f_ready),
        .out_valid(COL_VALID),
        .out_data(COL_WORD),
        .out_ready(COL_READY)
    );
    // ------------------------------------------------------------
    // Registers and outputs
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            s <= '0;
            s.mode <= dca_pkg::M_RUN;
            s.dll <= 1'b1;
            s.rl <= 4'h1;
        end else if (CLK_EN) begin
            s <= n;
        end
    end
    assign BANK_OPEN = s.open;
    assign AP_FIRE = s.fire;
    assign DLL_ON = s.dll;
    assign SELF_REF = s.sref;
    assign REF_BUSY = s.bsy;
    assign REF_ROW = s.row;
    assign RD_LAT = s.rl;
    assign WR_LAT = s.wl;
    assign CMD_OVERRUN = s.ovr;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_prea;
        @(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && s.mode == dca_pkg::M_RUN && cmd == dca_pkg::C_PREA) |=> BANK_OPEN == 8'h0;
    endproperty
    a_prea: assert property (p_prea) else $error("precharge all left a bank open");
    property p_apfire;
        @(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && s.ap[3] == 5'h1) |=> (AP_FIRE[3] && !BANK_OPEN[3]);
    endproperty
    a_apfire: assert property (p_apfire) else $error("auto precharge missed bank 3");
    property p_aprd;
        @(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && s.mode == dca_pkg::M_RUN && cmd == dca_pkg::C_RD && apb && bank == 3'h3)
        |=> s.ap[3] == ap_len($past(al), $past(COL_LAT), $past(bl8), 1'b0, 3'h0);
    endproperty
    a_aprd: assert property (p_aprd) else $error("read auto precharge delay wrong");
    property p_sref_dll;
        @(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && SELF_REF) |-> !DLL_ON;
    endproperty
    a_sref_dll: assert property (p_sref_dll) else $error("DLL on during self refresh");
    property p_nop;
        @(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && s.mode == dca_pkg::M_RUN && cmd == dca_pkg::C_NOP && s.fire == 8'h0
         && s.ap == '0) |=> (BANK_OPEN == $past(BANK_OPEN) && REF_ROW == $past(REF_ROW));
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");
    property p_lat;
        @(posedge SYS_CLK) disable iff (RST)
        (CLK_EN ##1 CLK_EN) |-> WR_LAT + 4'h1 == RD_LAT;
    endproperty
    a_lat: assert property (p_lat) else $error("write latency not read latency minus one");
    property p_ref;
        @(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && s.mode == dca_pkg::M_RUN && cmd == dca_pkg::C_REF)
        |=> (REF_BUSY && BANK_OPEN == 8'h0 && REF_ROW == $past(REF_ROW) + 14'h1);
    endproperty
    a_ref: assert property (p_ref) else $error("refresh effects wrong");
    property p_al;
        @(posedge SYS_CLK) disable iff (RST)
        CLK_EN |-> al <= dca_pkg::AL_MAX;
    endproperty
    a_al: assert property (p_al) else $error("additive latency above six");
endmodule

// ===== core/dca_pkg.sv
// Constants and types for the memory command and access logic
package dca_pkg;
    localparam int CLK_NS = 10;
    localparam int REFRESH_CYCLE_TIME_NS = 130;
    localparam int REFRESH_CYCLE_TIME_CYC = (REFRESH_CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int SRT_NS = 7800;
    localparam int SRT_CYC = SRT_NS / CLK_NS;
    localparam logic [2:0] BL8_CODE = 3'h3;
    localparam logic [2:0] AL_MAX = 3'h6;
    localparam int PINW = 22;
    localparam int P_CKE = 21;
    localparam int P_CS = 20;
    localparam int P_RAS = 19;
    localparam int P_CAS = 18;
    localparam int P_WE = 17;
    localparam int P_BA = 14;
    localparam int P_AP = 10;
    localparam int COLW = 10;
    localparam int FW = 16;
    localparam int FD = 8;
    localparam int PIPE = 6;
    typedef enum logic [2:0] {
        M_RUN = 3'h1,
        M_SREF = 3'h2,
        M_EXIT = 3'h4
    } dca_mode_t;
    typedef enum logic [2:0] {
        C_NOP = 3'h0,
        C_ACT = 3'h1,
        C_RD = 3'h2,
        C_WR = 3'h3,
        C_PRE = 3'h4,
        C_PREA = 3'h5,
        C_REF = 3'h6,
        C_SRE = 3'h7
    } dca_cmd_t;
endpackage

// ===== core/dca_fifo.sv
// Column command FIFO with valid and ready on both sides
`timescale 1ns/1ns
module dca_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [W-1:0] head;
    } dca_fifo_t;
    dca_fifo_t s, n;
    logic push;
    logic pop;
    always_comb begin
        in_ready = s.cnt != (AW+1)'(D);
        out_valid = s.ov;
        out_data = s.head;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        n = s;
        if (push) begin
            n.mem[s.wp] = in_data;
            n.wp = s.wp + 1'b1;
        end
        if (pop) begin
            n.rp = s.rp + 1'b1;
        end
        n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // Head and valid registered so the read side sees flops only
        n.ov = n.cnt != '0;
        n.head = n.mem[n.rp];
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end
endmodule

// ===== tb/dca_ctl_model.sv
// Memory controller model that drives command pins toward the device
`timescale 1ns/1ns
module dca_ctl_model #(
    parameter int GAP = 2,
    parameter int XSNR = 4
) (
    input wire logic clk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [2:0] bank_sel,
    output logic [13:0] addr
);
    int cyc = 0;
    int t0 = 0;
    logic term_on = 1'h1;

    initial begin
        cke = 1'h1;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        bank_sel = 3'h0;
        addr = 14'h0000;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    // ------------------------------------------------------------
    // Command issue
    // ------------------------------------------------------------
    // Held two clocks so the device synchroniser agrees exactly once
    task automatic cmd(input logic [3:0] pins, input logic ck, input logic [2:0] bank, input logic [13:0] a);
        @(posedge clk);
        t0 = cyc;
        if (pins == 4'h1 && ck == 1'h0) begin
            term_on = 1'h0;
        end
        cke <= ck;
        {cs_n, ras_n, cas_n, we_n} <= pins;
        bank_sel <= bank;
        addr <= a;
        repeat (2) @(posedge clk);
        {cs_n, ras_n, cas_n, we_n} <= 4'h7;
        bank_sel <= ~bank;
        addr <= ~a;
        // Five clocks per command: no burst interrupt, spacing kept
        repeat (GAP) @(posedge clk);
    endtask

    // Clock never halted, so it is stable before exit
    task automatic sr_exit;
        cmd(4'h7, 1'h1, 3'h0, 14'h0000);
        repeat (XSNR) @(posedge clk);
        cmd(4'h1, 1'h1, 3'h0, 14'h0000);
    endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the memory command and access logic
`timescale 1ns/1ns
module tb_top;
    localparam logic [3:0] K_ACT = 4'h3;
    localparam logic [3:0] K_RD = 4'h5;
    localparam logic [3:0] K_WR = 4'h4;
    localparam logic [3:0] K_PREA = 4'h2;
    localparam logic [3:0] K_REF = 4'h1;
    localparam logic [3:0] K_NOP = 4'h7;
    localparam logic [3:0] K_DES = 4'hD;
    logic SYS_CLK = 1'h0;
    logic RST = 1'h1;
    logic cke, cs_n, ras_n, cas_n, we_n, col_valid, dll_on, self_ref, ref_busy, cmd_overrun;
    logic [2:0] bank_sel;
    logic [13:0] addr, ref_row;
    logic [2:0] burst_code = 3'h3;
    logic [2:0] add_lat = 3'h2;
    logic col_ready = 1'h0;
    logic clk_en = 1'h1;
    logic burst_type = 1'h0;
    logic [2:0] col_lat = 3'h3;
    logic [dca_pkg::FW-1:0] col_word;
    logic [7:0] bank_open, ap_fire;
    logic [7:0] ap_seen = 8'h00;
    logic [3:0] rd_lat, wr_lat;
    int bad_count = 0;
    int comparisons = 0;
    int busy_cnt = 0;
    int pops = 0;
    int ap_at = 0;
    int p0;

    always #5 SYS_CLK = ~SYS_CLK;

    dca_core dca_core_i (.SYS_CLK(SYS_CLK), .RST(RST), .CLK_EN(clk_en), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
        .CAS_N(cas_n), .WE_N(we_n), .BANK_SEL(bank_sel), .ADDR(addr), .BURST_CODE(burst_code),
        .BURST_TYPE(burst_type), .ADD_LAT(add_lat), .COL_LAT(col_lat), .WR_REC(3'h2), .COL_READY(col_ready),
        .COL_VALID(col_valid), .COL_WORD(col_word), .BANK_OPEN(bank_open), .AP_FIRE(ap_fire),
        .DLL_ON(dll_on), .SELF_REF(self_ref), .REF_BUSY(ref_busy), .REF_ROW(ref_row), .RD_LAT(rd_lat),
        .WR_LAT(wr_lat), .CMD_OVERRUN(cmd_overrun));

    dca_ctl_model dca_ctl_model_i (.clk(SYS_CLK), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .bank_sel(bank_sel), .addr(addr));

    // ------------------------------------------------------------
    // Monitors
    // ------------------------------------------------------------
    always @(posedge SYS_CLK) begin
        if (ref_busy === 1'h1) busy_cnt <= busy_cnt + 1;
        if (col_valid === 1'h1 && col_ready === 1'h1 && clk_en === 1'h1) pops <= pops + 1;
        if (ap_fire !== 8'h00) begin
            ap_seen <= ap_fire;
            // Stamp taken before the count steps, pulse seen one edge late
            ap_at <= dca_ctl_model_i.cyc - dca_ctl_model_i.t0 - 1;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    // Pins from the edge, then settle time for the three-flop sync
    task automatic op(input logic [3:0] p, input logic ck, input logic [2:0] b, input logic [13:0] a);
        dca_ctl_model_i.cmd(p, ck, b, a);
        repeat (4) @(posedge SYS_CLK);
        #1;
    endtask

    task automatic pop;
        @(posedge SYS_CLK);
        col_ready <= 1'h1;
        @(posedge SYS_CLK);
        col_ready <= 1'h0;
        @(posedge SYS_CLK);
        #1;
    endtask

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Whole sequence needs about 360 clocks
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        bad_count++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge SYS_CLK);
        RST <= 1'h0;
        @(posedge SYS_CLK);
        #1;
        chk("reset state", {8'h00, 1'h1, 1'h0, 14'h0000, 3'h0},
            {bank_open, dll_on, self_ref, ref_row, col_valid, cmd_overrun, ref_busy});
        for (int al = 0; al < 8; al++) begin
            @(posedge SYS_CLK);
            add_lat <= 3'(al);
            col_lat <= 3'(7 - al);
            repeat (3) @(posedge SYS_CLK);
            #1;
            chk("read delay", (al > 6 ? 6 : al) + 7 - al, rd_lat);
            chk("write delay", (al > 6 ? 6 : al) + 6 - al, wr_lat);
        end
        @(posedge SYS_CLK);
        add_lat <= 3'h2;
        col_lat <= 3'h3;
        // Column commands straight after activate rely on posting
        op(K_ACT, 1'h1, 3'h3, 14'h0011);
        op(K_ACT, 1'h1, 3'h5, 14'h0022);
        op(K_RD, 1'h1, 3'h3, 14'h32A5);
        @(posedge SYS_CLK);
        burst_type <= 1'h1;
        op(K_WR, 1'h1, 3'h5, 14'h03FE);
        op(K_DES, 1'h1, 3'h3, 14'h0123);
        op(K_NOP, 1'h1, 3'h6, 14'h3FFF);
        chk("open banks", 8'h28, bank_open);
        chk("read word", {1'h0, 1'h0, 1'h1, 3'h3, 10'h2A5}, col_word);
        pop();
        chk("write word", {1'h1, 1'h1, 1'h1, 3'h5, 10'h3FE}, col_word);
        pop();
        chk("queue empty", 1'h0, col_valid);
        @(posedge SYS_CLK);
        col_ready <= 1'h1;
        op(K_RD, 1'h1, 3'h3, 14'h0404);
        repeat (8) @(posedge SYS_CLK);
        chk("read close bank", 8'h08, ap_seen);
        chk("read close time", 11, ap_at);
        chk("banks after read close", 8'h20, bank_open);
        burst_code <= 3'h2;
        op(K_WR, 1'h1, 3'h5, 14'h0408);
        repeat (8) @(posedge SYS_CLK);
        chk("write close bank", 8'h20, ap_seen);
        chk("write close time", 13, ap_at);
        chk("banks after write close", 8'h00, bank_open);
        op(K_ACT, 1'h1, 3'h0, 14'h0001);
        op(K_ACT, 1'h1, 3'h7, 14'h0002);
        chk("two open", 8'h81, bank_open);
        op(K_PREA, 1'h1, 3'h2, 14'h0400);
        chk("all closed", 8'h00, bank_open);
        op(K_ACT, 1'h1, 3'h2, 14'h0003);
        op(K_REF, 1'h1, 3'h6, 14'h2AAA);
        chk("refresh busy", 1'h1, ref_busy);
        chk("refresh row", 14'h0001, ref_row);
        chk("idle after refresh", 8'h00, bank_open);
        repeat (20) @(posedge SYS_CLK);
        chk("refresh span", 13, busy_cnt);
        op(K_REF, 1'h0, 3'h0, 14'h0000);
        chk("self refresh on", 2'h1, {dll_on, self_ref});
        chk("termination off", 1'h0, dca_ctl_model_i.term_on);
        op(K_ACT, 1'h0, 3'h1, 14'h0005);
        chk("ignored in self refresh", 8'h00, bank_open);
        dca_ctl_model_i.sr_exit();
        repeat (4) @(posedge SYS_CLK);
        #1;
        chk("self refresh off", 2'h2, {dll_on, self_ref});
        chk("row after exit", 14'h0002, ref_row);
        @(posedge SYS_CLK);
        col_ready <= 1'h0;
        burst_code <= 3'h3;
        burst_type <= 1'h0;
        op(K_ACT, 1'h1, 3'h4, 14'h0007);
        chk("overrun clear", 1'h0, cmd_overrun);
        for (int i = 0; i < 9; i++) begin
            op(K_RD, 1'h1, 3'h4, 14'(8 * i));
        end
        chk("overrun set", 1'h1, cmd_overrun);
        p0 = pops;
        // Enable low must hold the queue and its head word
        @(posedge SYS_CLK);
        clk_en <= 1'h0;
        col_ready <= 1'h1;
        repeat (5) @(posedge SYS_CLK);
        #1;
        chk("frozen queue", 1'h1, col_valid);
        chk("frozen head", {1'h0, 1'h0, 1'h1, 3'h4, 10'h000}, col_word);
        @(posedge SYS_CLK);
        clk_en <= 1'h1;
        repeat (20) @(posedge SYS_CLK);
        #1;
        chk("drained words", 8, pops - p0);
        chk("drained empty", 2'h1, {col_valid, cmd_overrun});
        close_out();
    end
endmodule
